// ===== logic/prs_pkg.sv
// package for the power-on reset sequencer: states, timing counts, carriers
package prs_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // short and long delay from input pad enable to core reset release, in us
  localparam int unsigned PAD_DLY_SHORT_US = 4;
  localparam int unsigned PAD_DLY_LONG_US = 500;
  localparam int unsigned PAD_DLY_SHORT_CYC = (PAD_DLY_SHORT_US * (CLK_HZ / 1000000) > 0) ?
    PAD_DLY_SHORT_US * (CLK_HZ / 1000000) : 1;
  localparam int unsigned PAD_DLY_LONG_CYC = (PAD_DLY_LONG_US * (CLK_HZ / 1000000) > 0) ?
    PAD_DLY_LONG_US * (CLK_HZ / 1000000) : 1;
  localparam int unsigned CNT_W = 14;
  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
  // rc oscillator rate select code
  localparam logic RC_RATE_SLOW = 1'h0;
  localparam logic RC_RATE_FAST = 1'h1;

  typedef enum logic [9:0] {
    PRS_OFF = 10'h001,
    PRS_NVM_RST = 10'h002,
    PRS_CFG_LOAD = 10'h004,
    PRS_IN_RST = 10'h008,
    PRS_IN_EN = 10'h010,
    PRS_PAD_DLY = 10'h020,
    PRS_LUT_RST = 10'h040,
    PRS_SEQ_INIT = 10'h080,
    PRS_POR_HIGH = 10'h100,
    PRS_RUN = 10'h200
  } prs_state_t;

  // stage requests issued to the rest of the device
  typedef struct packed {
    logic nvm_reset;
    logic cfg_load;
    logic in_pin_reset;
    logic in_pin_enable;
    logic edge_det_enable;
    logic lut_reset;
    logic lut_enable;
    logic seq_init;
    logic seq_enable;
    logic por_matrix;
    logic out_pin_oe_n;
  } prs_ctrl_t;

  // completion strobes returned by each stage
  typedef struct packed {
    logic nvm_reset_done;
    logic cfg_load_done;
    logic in_pin_reset_done;
    logic lut_reset_done;
    logic seq_init_done;
  } prs_done_t;

  // oscillator enables, one per source and divider stage
  typedef struct packed {
    logic resistor_cap_oscillator_en;
    logic rc_rate;
    logic lf_osc_en;
    logic ring_osc_en;
    logic rc_div1_en;
    logic rc_div2_en;
    logic ring_div1_en;
    logic ring_div2_en;
    logic lf_div1_en;
  } prs_osc_t;

  typedef struct packed {
    prs_state_t state;
    logic [CNT_W-1:0] cnt;
    prs_ctrl_t ctrl;
    prs_osc_t osc;
    logic [1:0] supply_sync;
    logic [1:0] shutdown_sync;
  } prs_reg_t;
endpackage : prs_pkg

// ===== logic/prs_sequencer.sv
// power-on reset sequencer with oscillator shutdown gating
// Function
// [R1] each oscillator runs while its shutdown request is low, stops while high
// [R2] shutdown request overrides every other oscillator enable condition
// [R3] rc oscillator has two selectable rates; low-frequency and ring sources exist
// [R4] two divider stages after rc and ring, one after low-frequency oscillator
// [R5] sequence starts when supply-detect shows rising supply crossed threshold
// [R6] all pins high impedance while powered down and throughout the sequence
// [R7] first reset the non-volatile memory, then load configuration and routing
// [R8] after configuration load, hold input pins in reset, then enable them
// [R9] after input pins enabled, reset lookup tables, then release them
// [R10] after lookup tables, initialise delays, rc oscillator, flops, latches, pipe
// [R11] internal reset output rises only after all other blocks initialised
// [R12] output pins leave high impedance last, after internal reset output rose
// [R13] before memory reset all block outputs low, output pins high impedance
// [R14] block outputs undefined until configuration load done; nothing relies on them
// [R15] first init step forces input and lut outputs low; only edge detector active
// [R16] every internal block starts from a low output level
// [R17] in power-up window blocks powered but held in reset, outputs high impedance
// [R18] release in four groups: inputs, luts, sequential cells, reset output; code releases the last two together in PRS_POR_HIGH
// [R19] on supply fall all io buffers disabled once reset output drops
// [R20] configuration bit picks short or long pad-enable to core release delay
// [R21] each stage advances only after the previous stage reports completion
// [R22] supply-detect loss at any point returns to initial state
`timescale 1ns/1ps
module prs_sequencer #(
  parameter int unsigned PAD_DLY_SHORT = prs_pkg::PAD_DLY_SHORT_CYC,
  parameter int unsigned PAD_DLY_LONG = prs_pkg::PAD_DLY_LONG_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic supply_ok,
  input wire logic osc_shutdown_request,
  input wire logic rc_rate_sel,
  input wire logic pad_delay_long,
  input wire prs_pkg::prs_done_t done,
  output prs_pkg::prs_ctrl_t ctrl,
  output prs_pkg::prs_osc_t osc,
  output prs_pkg::prs_state_t state
);
  prs_pkg::prs_reg_t st_reg;
  prs_pkg::prs_reg_t st_next;
  logic supply_s;
  logic shutdown_s;
  logic [prs_pkg::CNT_W-1:0] dly_load;
  logic osc_want;

  assign supply_s = st_reg.supply_sync[1];
  assign shutdown_s = st_reg.shutdown_sync[1];
  // the long delay must fit the counter width
  assign dly_load = pad_delay_long ? prs_pkg::CNT_W'(PAD_DLY_LONG) : // R20
                                     prs_pkg::CNT_W'(PAD_DLY_SHORT);

  function automatic prs_pkg::prs_ctrl_t ctrl_of(input prs_pkg::prs_state_t s);
    prs_pkg::prs_ctrl_t c;
    c = '0;
    c.out_pin_oe_n = 1'b1; // R6
    unique case (s)
      prs_pkg::PRS_OFF: begin
      end
      prs_pkg::PRS_NVM_RST: begin
        c.nvm_reset = 1'b1; // R7
      end
      prs_pkg::PRS_CFG_LOAD: begin
        c.cfg_load = 1'b1; // R7
      end
      prs_pkg::PRS_IN_RST: begin
        c.in_pin_reset = 1'b1; // R8 R15
        c.lut_reset = 1'b1; // R15
        c.edge_det_enable = 1'b1; // R15
      end
      prs_pkg::PRS_IN_EN, prs_pkg::PRS_PAD_DLY: begin
        c.in_pin_enable = 1'b1; // R8 R18
        c.lut_reset = 1'b1;
        c.edge_det_enable = 1'b1;
      end
      prs_pkg::PRS_LUT_RST: begin
        c.in_pin_enable = 1'b1;
        c.edge_det_enable = 1'b1;
        c.lut_reset = 1'b1; // R9
      end
      prs_pkg::PRS_SEQ_INIT: begin
        c.in_pin_enable = 1'b1;
        c.edge_det_enable = 1'b1;
        c.lut_enable = 1'b1; // R9 R18
        c.seq_init = 1'b1; // R10
      end
      prs_pkg::PRS_POR_HIGH: begin
        c.in_pin_enable = 1'b1;
        c.edge_det_enable = 1'b1;
        c.lut_enable = 1'b1;
        c.seq_enable = 1'b1; // R18
        c.por_matrix = 1'b1; // R11
      end
      prs_pkg::PRS_RUN: begin
        c.in_pin_enable = 1'b1;
        c.edge_det_enable = 1'b1;
        c.lut_enable = 1'b1;
        c.seq_enable = 1'b1;
        c.por_matrix = 1'b1;
        c.out_pin_oe_n = 1'b0; // R12
      end
      default: begin
      end
    endcase
    return c;
  endfunction : ctrl_of

  always_comb begin
    st_next = st_reg;
    osc_want = 1'b0;
    if (clk_en) begin
      st_next.supply_sync = {st_reg.supply_sync[0], supply_ok};
      st_next.shutdown_sync = {st_reg.shutdown_sync[0], osc_shutdown_request};
      if (st_reg.cnt != prs_pkg::CNT_ZERO) begin
        st_next.cnt = st_reg.cnt - prs_pkg::CNT_ONE;
      end
      if (!supply_s) begin
        st_next.state = prs_pkg::PRS_OFF; // R22 R19
        st_next.cnt = prs_pkg::CNT_ZERO;
      end else begin
        unique case (st_reg.state)
          prs_pkg::PRS_OFF: begin
            st_next.state = prs_pkg::PRS_NVM_RST; // R5 R17
          end
          prs_pkg::PRS_NVM_RST: begin
            if (done.nvm_reset_done) begin
              st_next.state = prs_pkg::PRS_CFG_LOAD; // R21
            end
          end
          prs_pkg::PRS_CFG_LOAD: begin
            // stage outputs only trusted once this completes
            if (done.cfg_load_done) begin
              st_next.state = prs_pkg::PRS_IN_RST; // R14 R21
            end
          end
          prs_pkg::PRS_IN_RST: begin
            if (done.in_pin_reset_done) begin
              st_next.state = prs_pkg::PRS_IN_EN; // R21
            end
          end
          prs_pkg::PRS_IN_EN: begin
            st_next.state = prs_pkg::PRS_PAD_DLY;
            st_next.cnt = dly_load; // R20
          end
          prs_pkg::PRS_PAD_DLY: begin
            if (st_reg.cnt == prs_pkg::CNT_ONE || st_reg.cnt == prs_pkg::CNT_ZERO) begin
              st_next.state = prs_pkg::PRS_LUT_RST; // R20
            end
          end
          prs_pkg::PRS_LUT_RST: begin
            if (done.lut_reset_done) begin
              st_next.state = prs_pkg::PRS_SEQ_INIT; // R21
            end
          end
          prs_pkg::PRS_SEQ_INIT: begin
            if (done.seq_init_done) begin
              st_next.state = prs_pkg::PRS_POR_HIGH; // R11 R21
            end
          end
          prs_pkg::PRS_POR_HIGH: begin
            st_next.state = prs_pkg::PRS_RUN; // R12
          end
          prs_pkg::PRS_RUN: begin
          end
          default: begin
            st_next.state = prs_pkg::PRS_OFF;
          end
        endcase
      end
      st_next.ctrl = ctrl_of(st_next.state);
      // every source runs in all powered states; staging them would save little
      osc_want = supply_s && (st_next.state != prs_pkg::PRS_OFF);
      osc_want = osc_want && !shutdown_s; // R1 R2
      st_next.osc.resistor_cap_oscillator_en = osc_want; // R10
      st_next.osc.lf_osc_en = osc_want; // R3
      st_next.osc.ring_osc_en = osc_want; // R3
      // rate held low while off so the idle outputs stay all low
      if (rc_rate_sel && st_next.state != prs_pkg::PRS_OFF) begin
        st_next.osc.rc_rate = prs_pkg::RC_RATE_FAST; // R3 R13
      end else begin
        st_next.osc.rc_rate = prs_pkg::RC_RATE_SLOW; // R3
      end
      st_next.osc.rc_div1_en = osc_want; // R4
      st_next.osc.rc_div2_en = osc_want;
      st_next.osc.ring_div1_en = osc_want;
      st_next.osc.ring_div2_en = osc_want;
      st_next.osc.lf_div1_en = osc_want;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg.state <= prs_pkg::PRS_OFF; // R13 R16
      st_reg.cnt <= prs_pkg::CNT_ZERO;
      st_reg.ctrl <= '0;
      st_reg.ctrl.out_pin_oe_n <= 1'b1; // R6
      st_reg.osc <= '0;
      st_reg.supply_sync <= 2'h0;
      st_reg.shutdown_sync <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ctrl = st_reg.ctrl;
  assign osc = st_reg.osc;
  assign state = st_reg.state;

  property p_pins_hiz;
    @(posedge clk) disable iff (srst)
      (st_reg.state != prs_pkg::PRS_RUN) |-> st_reg.ctrl.out_pin_oe_n;
  endproperty
  a_pins_hiz: assert property (p_pins_hiz) else $error("pins driven before run"); // R6

  property p_shutdown_wins;
    @(posedge clk) disable iff (srst)
      (clk_en && shutdown_s) |=> !st_reg.osc.resistor_cap_oscillator_en && !st_reg.osc.ring_osc_en;
  endproperty
  a_shutdown_wins: assert property (p_shutdown_wins) else $error("osc on in shutdown"); // R2

  property p_osc_runs;
    @(posedge clk) disable iff (srst)
      (clk_en && !shutdown_s && supply_s && st_reg.state == prs_pkg::PRS_RUN)
        |=> st_reg.osc.lf_osc_en;
  endproperty
  a_osc_runs: assert property (p_osc_runs) else $error("osc off without shutdown"); // R1

  property p_cfg_after_nvm;
    @(posedge clk) disable iff (srst)
      $rose(st_reg.ctrl.cfg_load) |-> $past(st_reg.ctrl.nvm_reset);
  endproperty
  a_cfg_after_nvm: assert property (p_cfg_after_nvm) else $error("cfg load not after nvm"); // R7

  property p_oe_after_por;
    @(posedge clk) disable iff (srst)
      $fell(st_reg.ctrl.out_pin_oe_n) |-> $past(st_reg.ctrl.por_matrix);
  endproperty
  a_oe_after_por: assert property (p_oe_after_por) else $error("pins before por"); // R12

  property p_por_after_seq;
    @(posedge clk) disable iff (srst)
      $rose(st_reg.ctrl.por_matrix) |-> $past(st_reg.ctrl.seq_init);
  endproperty
  a_por_after_seq: assert property (p_por_after_seq) else $error("por rose early"); // R11

  property p_supply_loss;
    @(posedge clk) disable iff (srst)
      (clk_en && !supply_s) |=> st_reg.state == prs_pkg::PRS_OFF && st_reg.ctrl.out_pin_oe_n
        && !st_reg.ctrl.por_matrix;
  endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("no return on supply loss"); // R22

  property p_stage_wait;
    @(posedge clk) disable iff (srst)
      (clk_en && supply_s && st_reg.state == prs_pkg::PRS_LUT_RST && !done.lut_reset_done)
        |=> st_reg.state == prs_pkg::PRS_LUT_RST;
  endproperty
  a_stage_wait: assert property (p_stage_wait) else $error("stage advanced early"); // R21

  property p_lut_after_in;
    @(posedge clk) disable iff (srst)
      $rose(st_reg.ctrl.lut_enable) |-> st_reg.ctrl.in_pin_enable && !st_reg.ctrl.seq_enable;
  endproperty
  a_lut_after_in: assert property (p_lut_after_in) else $error("release order broken"); // R18

  property p_pad_delay;
    @(posedge clk) disable iff (srst)
      (clk_en && st_reg.state == prs_pkg::PRS_IN_EN && supply_s && !pad_delay_long)
        |=> st_reg.cnt == prs_pkg::CNT_W'(PAD_DLY_SHORT);
  endproperty
  a_pad_delay: assert property (p_pad_delay) else $error("short pad delay wrong"); // R20

  property p_off_quiet;
    @(posedge clk) disable iff (srst)
      (st_reg.state == prs_pkg::PRS_OFF)
        |-> st_reg.osc == '0 && $countones(st_reg.ctrl) == 1 && st_reg.ctrl.out_pin_oe_n;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("outputs not idle while off"); // R13

  property p_enter_nvm;
    @(posedge clk) disable iff (srst)
      (clk_en && supply_s && st_reg.state == prs_pkg::PRS_OFF)
        |=> st_reg.state == prs_pkg::PRS_NVM_RST && st_reg.ctrl.nvm_reset;
  endproperty
  a_enter_nvm: assert property (p_enter_nvm) else $error("memory reset not first"); // R5

  property p_lut_order;
    @(posedge clk) disable iff (srst)
      $rose(st_reg.ctrl.lut_enable)
        |-> $past(st_reg.ctrl.lut_reset) && !st_reg.ctrl.lut_reset;
  endproperty
  a_lut_order: assert property (p_lut_order) else $error("luts released before reset"); // R9

  property p_first_init;
    @(posedge clk) disable iff (srst)
      (st_reg.state == prs_pkg::PRS_IN_RST)
        |-> st_reg.ctrl.in_pin_reset && st_reg.ctrl.lut_reset && st_reg.ctrl.edge_det_enable
        && !st_reg.ctrl.in_pin_enable && !st_reg.ctrl.lut_enable;
  endproperty
  a_first_init: assert property (p_first_init) else $error("first init step wrong"); // R15

  property p_load_quiet;
    @(posedge clk) disable iff (srst)
      (st_reg.state == prs_pkg::PRS_NVM_RST || st_reg.state == prs_pkg::PRS_CFG_LOAD)
        |-> st_reg.ctrl.out_pin_oe_n && !st_reg.ctrl.in_pin_enable && !st_reg.ctrl.lut_enable
        && !st_reg.ctrl.seq_enable && !st_reg.ctrl.por_matrix;
  endproperty
  a_load_quiet: assert property (p_load_quiet) else $error("stage live during load"); // R17

  property p_fall_io;
    @(posedge clk) disable iff (srst)
      $fell(st_reg.ctrl.por_matrix)
        |-> !st_reg.ctrl.in_pin_enable && st_reg.ctrl.out_pin_oe_n;
  endproperty
  a_fall_io: assert property (p_fall_io) else $error("io left on after reset fell"); // R19

  property p_long_delay;
    @(posedge clk) disable iff (srst)
      (clk_en && st_reg.state == prs_pkg::PRS_IN_EN && supply_s && pad_delay_long)
        |=> st_reg.cnt == prs_pkg::CNT_W'(PAD_DLY_LONG);
  endproperty
  a_long_delay: assert property (p_long_delay) else $error("long pad delay wrong"); // R20

  property p_nvm_wait;
    @(posedge clk) disable iff (srst)
      (clk_en && supply_s && st_reg.state == prs_pkg::PRS_NVM_RST && !done.nvm_reset_done)
        |=> st_reg.state == prs_pkg::PRS_NVM_RST;
  endproperty
  a_nvm_wait: assert property (p_nvm_wait) else $error("memory stage advanced early"); // R21

  property p_rate_follow;
    @(posedge clk) disable iff (srst)
      (clk_en && supply_s && st_reg.state != prs_pkg::PRS_OFF)
        |=> st_reg.osc.rc_rate == $past(rc_rate_sel);
  endproperty
  a_rate_follow: assert property (p_rate_follow) else $error("rc rate not selected"); // R3

  property p_shutdown_all;
    @(posedge clk) disable iff (srst)
      (clk_en && shutdown_s) |=> !st_reg.osc.lf_osc_en && !st_reg.osc.rc_div1_en
        && !st_reg.osc.rc_div2_en && !st_reg.osc.ring_div1_en && !st_reg.osc.ring_div2_en
        && !st_reg.osc.lf_div1_en;
  endproperty
  a_shutdown_all: assert property (p_shutdown_all) else $error("clock on in shutdown"); // R1
endmodule : prs_sequencer

// ===== tb/tb_top.sv
// self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    prs_pkg::prs_state_t st;
    logic [4:0] dn;
    logic [10:0] m;
    logic [10:0] v;
  } prs_row_t;
  // short counts keep the pad delay visible without a long run
  localparam int unsigned SHORT_N = 3;
  localparam int unsigned LONG_N = 10;
  localparam prs_row_t ROWS [9] = '{
    '{prs_pkg::PRS_NVM_RST, 5'h10, 11'h7FF, 11'h401},
    '{prs_pkg::PRS_CFG_LOAD, 5'h08, 11'h7FF, 11'h201},
    '{prs_pkg::PRS_IN_RST, 5'h04, 11'h7FF, 11'h161},
    '{prs_pkg::PRS_IN_EN, 5'h00, 11'h7FF, 11'h0E1},
    '{prs_pkg::PRS_PAD_DLY, 5'h00, 11'h7FF, 11'h0E1},
    '{prs_pkg::PRS_LUT_RST, 5'h02, 11'h7FF, 11'h0E1},
    '{prs_pkg::PRS_SEQ_INIT, 5'h01, 11'h73F, 11'h019},
    '{prs_pkg::PRS_POR_HIGH, 5'h00, 11'h727, 11'h007},
    '{prs_pkg::PRS_RUN, 5'h00, 11'h723, 11'h002}
  };
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic clk_en = 1'h1;
  logic supply_ok = 1'h0;
  logic osc_shutdown_request = 1'h0;
  logic rc_rate_sel = 1'h1;
  logic pad_delay_long = 1'h0;
  prs_pkg::prs_done_t done = 5'h00;
  prs_pkg::prs_ctrl_t ctrl;
  prs_pkg::prs_osc_t osc;
  prs_pkg::prs_state_t state;
  int miscompares = 0;
  int comparisons = 0;
  int pad_cnt = 0;
  int pad_base = 0;

  always #25 clk = ~clk;

  prs_sequencer #(.PAD_DLY_SHORT(SHORT_N), .PAD_DLY_LONG(LONG_N)) u_prs_sequencer (
    .clk(clk),
    .srst(srst),
    .clk_en(clk_en),
    .supply_ok(supply_ok),
    .osc_shutdown_request(osc_shutdown_request),
    .rc_rate_sel(rc_rate_sel),
    .pad_delay_long(pad_delay_long),
    .done(done),
    .ctrl(ctrl),
    .osc(osc),
    .state(state)
  );

  always @(posedge clk) begin
    if (state === prs_pkg::PRS_PAD_DLY) begin
      pad_cnt <= pad_cnt + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_state(input prs_pkg::prs_state_t s);
    int n;
    n = 0;
    while (state !== s && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(16'(state), 16'(s));
  endtask : wait_state

  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk(16'(state), 16'(prs_pkg::PRS_OFF));
    chk(16'(ctrl), 16'h0001);
    chk(16'(osc), 16'h0000);
    @(posedge clk) srst <= 1'h0;
    repeat (4) @(negedge clk);
    chk(16'(state), 16'(prs_pkg::PRS_OFF));
    chk(16'(osc), 16'h0000);
    $display("test reset done");
    // ordinary walk: each stage held until its own completion arrives
    @(posedge clk) supply_ok <= 1'h1;
    foreach (ROWS[i]) begin
      wait_state(ROWS[i].st);
      chk(16'(ctrl & ROWS[i].m), 16'(ROWS[i].v));
      chk(16'(osc), 16'h01FF);
      if (ROWS[i].dn != 5'h00) begin
        repeat (3) @(negedge clk);
        chk(16'(state), 16'(ROWS[i].st));
        @(posedge clk) done <= ROWS[i].dn;
      end
    end
    // pad delay state holds for the full loaded count
    chk(16'(pad_cnt), 16'(SHORT_N));
    $display("test walk done");
    @(posedge clk) begin
      done <= 5'h00;
      osc_shutdown_request <= 1'h1;
    end
    repeat (4) @(negedge clk);
    chk(16'(osc & 9'h17F), 16'h0000);
    chk(16'(ctrl & 11'h723), 16'h0002);
    @(posedge clk) osc_shutdown_request <= 1'h0;
    repeat (4) @(negedge clk);
    chk(16'(osc), 16'h01FF);
    $display("test shutdown done");
    @(posedge clk) supply_ok <= 1'h0;
    repeat (4) @(negedge clk);
    chk(16'(state), 16'(prs_pkg::PRS_OFF));
    chk(16'(ctrl), 16'h0001);
    chk(16'(osc), 16'h0000);
    $display("test supply fall done");
    // every completion except the memory one: the stage must not move
    @(posedge clk) begin
      supply_ok <= 1'h1;
      done <= 5'h0F;
    end
    wait_state(prs_pkg::PRS_NVM_RST);
    repeat (4) @(negedge clk);
    chk(16'(state), 16'(prs_pkg::PRS_NVM_RST));
    @(posedge clk) begin
      clk_en <= 1'h0;
      supply_ok <= 1'h0;
    end
    repeat (6) @(negedge clk);
    chk(16'(state), 16'(prs_pkg::PRS_NVM_RST));
    @(posedge clk) clk_en <= 1'h1;
    repeat (4) @(negedge clk);
    chk(16'(state), 16'(prs_pkg::PRS_OFF));
    chk(16'(ctrl), 16'h0001);
    $display("test abort done");
    // all completions already high: stages run back to back, long pad delay
    @(posedge clk) begin
      done <= 5'h1F;
      pad_delay_long <= 1'h1;
      rc_rate_sel <= 1'h0;
      supply_ok <= 1'h1;
    end
    pad_base = pad_cnt;
    wait_state(prs_pkg::PRS_RUN);
    chk(16'(pad_cnt - pad_base), 16'(LONG_N));
    chk(16'(osc), 16'h017F);
    chk(16'(ctrl & 11'h723), 16'h0002);
    $display("test back to back done");
    wrap_up();
  end

  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end
endmodule : tb_top
